// ### hdl/pss_pkg.sv
/*
 * Shared constants and types for the pipelined synchronous SRAM port.
 * Assumes both ends and the bench import it; one clock, core_clk.
 */
package pss_pkg;
    localparam int ADDR_W       = 10;
    localparam int LANES        = 4;
    localparam int LANE_W       = 8;
    localparam int DATA_W       = LANES * LANE_W;
    localparam int DEPTH        = 1 << ADDR_W;
    localparam int PIPE_LAT     = 2;
    localparam int SLEEP_CYC    = 2;
    localparam int FIFO_DEPTH   = 8;
    localparam int FIFO_AW      = 3;
    localparam logic [1:0] BURST_LAST = 2'h3;

    typedef enum logic [2:0] {
        PSS_CYC_IDLE,
        PSS_CYC_READ,
        PSS_CYC_WRITE,
        PSS_CYC_ABORT
    } pss_cyc_t;
endpackage

// ### hdl/pss_if.sv
/*
 * Pin bundle between the memory controller and the SRAM port.
 * Assumes the bench resolves the shared data lanes from the two enables.
 */
`timescale 1ns/1ps
interface pss_if;
    import pss_pkg::*;
    logic                clock_gate_n;
    logic                chip_select_first;
    logic                chip_select_second;
    logic                chip_select_third;
    logic                advance_or_load;
    logic                write_select;
    logic [LANES-1:0]    byte_lane_write;
    logic [ADDR_W-1:0]   addr;
    logic                output_drive_enable;
    logic                burst_order;
    logic                sleep_request;
    logic [DATA_W-1:0]   dq_from_mem;
    logic [LANES-1:0]    parity_lanes_from_mem;
    logic                dq_oe_mem;
    logic [DATA_W-1:0]   dq_from_ctl;
    logic [LANES-1:0]    parity_lanes_from_ctl;
    logic                dq_oe_ctl;
    logic [DATA_W-1:0]   dq_in;
    logic [LANES-1:0]    parity_lanes_in;

    modport mem (
        input  clock_gate_n, chip_select_first, chip_select_second, chip_select_third,
        input  advance_or_load, write_select, byte_lane_write, addr,
        input  output_drive_enable, burst_order, sleep_request, dq_in, parity_lanes_in,
        output dq_from_mem, parity_lanes_from_mem, dq_oe_mem
    );
    modport ctl (
        output clock_gate_n, chip_select_first, chip_select_second, chip_select_third,
        output advance_or_load, write_select, byte_lane_write, addr,
        output output_drive_enable, burst_order, sleep_request,
        output dq_from_ctl, parity_lanes_from_ctl, dq_oe_ctl,
        input  dq_in, parity_lanes_in
    );
endinterface

// ### hdl/pss_mem.sv
/*
 * Device end: pipelined common-I/O SRAM with burst counter, byte writes, sleep.
 * Assumes pins arrive from logic on core_clk; sleep_request is asynchronous.
 */
// Behaviour
// - Deselect unless all three selects active
// - Select, load, write_select high starts read
// - Advance during read reads next address
// - Read with drive enable low stays tri-stated
// - Continued read without enable is dummy
// - Select, load, write low, lane starts write
// - Advance continues write, lanes re-driven each cycle
// - Write with no lanes is abort
// - Continued write, no lanes: advance only
// - Clock gate high ignores the edge
// - Write cycles tri-state all lanes
// - Drive follows output-stage cycle and enable
// - Reset comes up deselected, tri-stated
// - Drive enable applied combinationally, masked on writes
// - write_select high on a selected load always decodes read
// - Any lane combination; selected lanes written only
// - Write data taken second edge after command
// - Four-beat burst, linear or interleaved order
// - Sleep: two cycles in/out, lanes tri-stated
`timescale 1ns/1ps
module pss_mem
    import pss_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Pins
    pss_if.mem        pin
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [LANE_W:0]     mem_q [LANES][DEPTH];

    // ------------------------------------------------------------
    // Sleep synchroniser and entry/exit timing
    // ------------------------------------------------------------
    logic                slp_s1_q;
    logic                slp_s2_q;
    logic [1:0]          slp_cnt_q;
    logic                asleep_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slp_s1_q <= 1'b0;
            slp_s2_q <= 1'b0;
        end
        else
        begin
            slp_s1_q <= pin.sleep_request;
            slp_s2_q <= slp_s1_q;
        end
    end

    // Mode flips only after the level has held SLEEP_CYC edges
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slp_cnt_q <= 2'h0;
            asleep_q  <= 1'b0;
        end
        else if (slp_s2_q == asleep_q)
        begin
            slp_cnt_q <= 2'h0;
        end
        else if (slp_cnt_q == 2'(SLEEP_CYC - 1))
        begin
            slp_cnt_q <= 2'h0;
            asleep_q  <= slp_s2_q;
        end
        else
        begin
            slp_cnt_q <= slp_cnt_q + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic                sel_all;
    logic                lanes_any;
    pss_cyc_t            cmd_cyc;
    logic                cmd_new;
    logic                stall;
    pss_cyc_t            burst_q;

    assign sel_all   = pin.chip_select_first & pin.chip_select_second
                     & pin.chip_select_third;
    assign lanes_any = ~&pin.byte_lane_write;
    assign stall     = pin.clock_gate_n | asleep_q | slp_s2_q;
    assign cmd_new   = ~pin.advance_or_load & sel_all;

    always_comb
    begin
        cmd_cyc = PSS_CYC_IDLE;
        if (!pin.advance_or_load)
        begin
            if (!sel_all)
                cmd_cyc = PSS_CYC_IDLE;
            else if (pin.write_select)
                cmd_cyc = PSS_CYC_READ;
            else if (lanes_any)
                cmd_cyc = PSS_CYC_WRITE;
            else
                cmd_cyc = PSS_CYC_ABORT;
        end
        else
        begin
            unique case (burst_q)
                PSS_CYC_IDLE:  cmd_cyc = PSS_CYC_IDLE;
                PSS_CYC_READ:  cmd_cyc = PSS_CYC_READ;
                PSS_CYC_WRITE,
                PSS_CYC_ABORT: cmd_cyc = lanes_any ? PSS_CYC_WRITE : PSS_CYC_ABORT;
                default:       cmd_cyc = PSS_CYC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Burst address counter
    // ------------------------------------------------------------
    logic [ADDR_W-1:0]   base_q;
    logic [1:0]          cnt_q;
    logic [1:0]          cnt_d;
    logic [1:0]          low_bits;
    logic [ADDR_W-1:0]   cur_addr;

    assign cnt_d    = cmd_new ? 2'h0 : cnt_q + 2'h1;
    // Linear wraps within four; interleaved xors the count in
    assign low_bits = pin.burst_order ? (base_q[1:0] ^ cnt_d)
                                      : (base_q[1:0] + cnt_d);
    assign cur_addr = cmd_new ? pin.addr : {base_q[ADDR_W-1:2], low_bits};

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_q  <= '0;
            cnt_q   <= 2'h0;
            burst_q <= PSS_CYC_IDLE;
        end
        else if (!stall)
        begin
            if (cmd_new)
                base_q <= pin.addr;
            // Abort of a new write uses no address; counter left as is
            if (!(cmd_new && cmd_cyc == PSS_CYC_ABORT))
                cnt_q <= cnt_d;
            burst_q <= cmd_cyc;
        end
    end

    // ------------------------------------------------------------
    // Two-stage pipeline: command -> middle -> data stage
    // ------------------------------------------------------------
    pss_cyc_t            s1_cyc_q;
    pss_cyc_t            s2_cyc_q;
    logic [ADDR_W-1:0]   s1_addr_q;
    logic [ADDR_W-1:0]   s2_addr_q;
    logic [LANES-1:0]    s1_bw_q;
    logic [LANES-1:0]    s2_bw_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_cyc_q  <= PSS_CYC_IDLE;
            s2_cyc_q  <= PSS_CYC_IDLE;
            s1_addr_q <= '0;
            s2_addr_q <= '0;
            s1_bw_q   <= '1;
            s2_bw_q   <= '1;
        end
        else if (asleep_q)
        begin
            // Pending accesses are dropped on sleep entry
            s1_cyc_q <= PSS_CYC_IDLE;
            s2_cyc_q <= PSS_CYC_IDLE;
        end
        else if (!stall)
        begin
            s1_cyc_q  <= cmd_cyc;
            s1_addr_q <= cur_addr;
            s1_bw_q   <= pin.byte_lane_write;
            s2_cyc_q  <= s1_cyc_q;
            s2_addr_q <= s1_addr_q;
            s2_bw_q   <= s1_bw_q;
        end
    end

    // ------------------------------------------------------------
    // Array access, one lane per generate step
    // ------------------------------------------------------------
    logic [DATA_W-1:0]   rd_data_q;
    logic [LANES-1:0]    rd_par_q;
    logic                wr_edge;

    // Write lands on the second edge after its command
    assign wr_edge = !stall && s2_cyc_q == PSS_CYC_WRITE;

    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
        logic [LANE_W:0] wr_word;

        assign wr_word = {pin.parity_lanes_in[g], pin.dq_in[g*LANE_W +: LANE_W]};
        always_ff @(posedge core_clk)
        begin
            if (wr_edge && !s2_bw_q[g])
                mem_q[g][s2_addr_q] <= wr_word;
        end

        always_ff @(posedge core_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                rd_data_q[g*LANE_W +: LANE_W] <= '0;
                rd_par_q[g]                   <= 1'b0;
            end
            else if (!stall && s1_cyc_q == PSS_CYC_READ)
            begin
                // Write to the same word lands on this edge; array still holds old data
                if (wr_edge && !s2_bw_q[g] && s2_addr_q == s1_addr_q)
                    {rd_par_q[g], rd_data_q[g*LANE_W +: LANE_W]} <= wr_word;
                else
                    {rd_par_q[g], rd_data_q[g*LANE_W +: LANE_W]} <= mem_q[g][s1_addr_q];
            end
        end
    end

    // ------------------------------------------------------------
    // Output drive; enable pin gates it without a clock
    // ------------------------------------------------------------
    assign pin.dq_from_mem           = rd_data_q;
    assign pin.parity_lanes_from_mem = rd_par_q;
    // Only reads at the data stage drive; writes/aborts/idle mask enable
    assign pin.dq_oe_mem = (s2_cyc_q == PSS_CYC_READ) && !asleep_q
                         && pin.output_drive_enable;
endmodule

// ### hdl/pss_fifo.sv
/*
 * Small valid/ready FIFO in the controller's write-data path.
 * Assumes single clock core_clk.
 */
`timescale 1ns/1ps
module pss_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [WIDTH-1:0] buf_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data  = buf_q[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge core_clk)
    begin
        if (push)
            buf_q[wp_q] <= in_data;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ### hdl/pss_ctl.sv
/*
 * Host end: memory controller issuing single or four-beat bursts.
 * Assumes user side on core_clk; write data queued in an 8-word FIFO.
 */
`timescale 1ns/1ps
module pss_ctl
    import pss_pkg::*;
(
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    // Command
    input  wire logic                    req_valid,
    output logic                         req_ready,
    input  wire logic                    req_write,
    input  wire logic                    req_burst,
    input  wire logic [ADDR_W-1:0]       req_addr,
    input  wire logic [LANES-1:0]        req_lanes_n,
    input  wire logic                    req_order,
    // Write data
    input  wire logic                    wd_valid,
    output logic                         wd_ready,
    input  wire logic [DATA_W+LANES-1:0] wd_data,
    // Read data
    output logic                         rd_valid,
    output logic [DATA_W+LANES-1:0]      rd_data,
    // Sleep and output enable
    input  wire logic                    sleep_req,
    input  wire logic                    oe_req,
    // Pins
    pss_if.ctl                           pin
);
    typedef enum logic [1:0] {PSS_C_IDLE, PSS_C_BURST} pss_cst_t;

    pss_cst_t            st_q;
    logic [1:0]          beat_q;
    logic                wr_q;
    logic [LANES-1:0]    lanes_q;
    logic [1:0]          wpipe_q;
    logic [2:0]          rpipe_q;
    logic                fifo_valid;
    logic [DATA_W+LANES-1:0] fifo_data;
    logic                issue;
    logic                beat;

    // Host stalls write commands and beats with lanes whenever the data queue is dry
    assign issue = st_q == PSS_C_IDLE && req_valid && !sleep_req
                 && (!req_write || fifo_valid || &req_lanes_n);
    assign beat  = st_q == PSS_C_BURST && (!wr_q || fifo_valid || &lanes_q);

    pss_fifo #(.WIDTH(DATA_W+LANES), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (wd_valid),
        .in_ready  (wd_ready),
        .in_data   (wd_data),
        .out_valid (fifo_valid),
        .out_ready (wpipe_q[1]),
        .out_data  (fifo_data)
    );

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q      <= PSS_C_IDLE;
            beat_q    <= 2'h0;
            wr_q      <= 1'b0;
            lanes_q   <= '1;
            req_ready <= 1'b0;
            pin.chip_select_first  <= 1'b0;
            pin.chip_select_second <= 1'b0;
            pin.chip_select_third  <= 1'b0;
            pin.advance_or_load    <= 1'b0;
            pin.write_select       <= 1'b1;
            pin.byte_lane_write    <= '1;
            pin.addr               <= '0;
            pin.clock_gate_n       <= 1'b0;
            pin.burst_order        <= 1'b0;
        end
        else
        begin
            req_ready <= issue;
            pin.burst_order <= req_order;
            unique case (st_q)
                PSS_C_IDLE:
                begin
                    pin.advance_or_load <= 1'b0;
                    {pin.chip_select_first, pin.chip_select_second,
                     pin.chip_select_third} <= {3{issue}};
                    pin.write_select    <= !req_write;
                    pin.byte_lane_write <= req_lanes_n;
                    pin.addr            <= req_addr;
                    if (issue)
                    begin
                        wr_q    <= req_write;
                        lanes_q <= req_lanes_n;
                        beat_q  <= 2'h0;
                        if (req_burst)
                            st_q <= PSS_C_BURST;
                    end
                end
                PSS_C_BURST:
                begin
                    pin.advance_or_load <= beat;
                    pin.byte_lane_write <= (wr_q && beat) ? lanes_q : '1;
                    pin.chip_select_first <= 1'b0;
                    if (beat)
                    begin
                        beat_q <= beat_q + 2'h1;
                        if (beat_q == BURST_LAST - 2'h1)
                            st_q <= PSS_C_IDLE;
                    end
                end
                default: st_q <= PSS_C_IDLE;
            endcase
        end
    end

    // Data phase two edges after each beat on the pins
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wpipe_q  <= 2'h0;
            rpipe_q  <= 3'h0;
            rd_valid <= 1'b0;
            rd_data  <= '0;
            pin.sleep_request         <= 1'b0;
            pin.output_drive_enable   <= 1'b0;
            pin.dq_oe_ctl             <= 1'b0;
            pin.dq_from_ctl           <= '0;
            pin.parity_lanes_from_ctl <= '0;
        end
        else
        begin
            wpipe_q <= {wpipe_q[0], (issue && req_write && !(&req_lanes_n))
                                    || (beat && wr_q && !(&lanes_q))};
            rpipe_q <= {rpipe_q[1:0], (issue && !req_write) || (beat && !wr_q)};
            pin.sleep_request       <= sleep_req;
            pin.output_drive_enable <= oe_req;
            pin.dq_oe_ctl           <= wpipe_q[1];
            {pin.parity_lanes_from_ctl, pin.dq_from_ctl} <= fifo_data;
            rd_valid <= rpipe_q[2];
            rd_data  <= {pin.parity_lanes_in, pin.dq_in};
        end
    end
endmodule

// ### tb/pss_properties.sv
/*
 * Concurrent checks on the pins between the controller and the SRAM port.
 * Assumes it is instantiated beside the pin interface, on core_clk alone.
 */
`timescale 1ns/1ps
module pss_properties
    import pss_pkg::*;
(
    // Clock and reset
    input wire logic             core_clk,
    input wire logic             rst_n,
    // Command pins
    input wire logic             clock_gate_n,
    input wire logic             chip_select_first,
    input wire logic             chip_select_second,
    input wire logic             chip_select_third,
    input wire logic             advance_or_load,
    input wire logic             write_select,
    input wire logic [LANES-1:0] byte_lane_write,
    input wire logic             output_drive_enable,
    input wire logic             sleep_request,
    // Lane drivers
    input wire logic             dq_oe_mem,
    input wire logic             dq_oe_ctl
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // Cycle decode
    // ----------------------------------------
    wire logic go  = !clock_gate_n && !sleep_request;
    wire logic sel = chip_select_first && chip_select_second && chip_select_third;
    wire logic ld  = go && !advance_or_load;
    // Drive expected unless masked or dropped by sleep
    wire logic rd_ok = dq_oe_mem || !output_drive_enable || sleep_request;

    sequence s_rd_load; ld && sel && write_select; endsequence
    sequence s_wr_load; ld && sel && !write_select && byte_lane_write != 4'hf; endsequence
    sequence s_ab_load; ld && sel && !write_select && byte_lane_write == 4'hf; endsequence
    sequence s_adv; go && advance_or_load; endsequence

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_read_latency: assert property (s_rd_load |-> ##2 rd_ok)
        else $error("read data not driven two edges after load");
    a_read_advance: assert property (s_rd_load ##1 s_adv |-> ##2 rd_ok)
        else $error("continued read beat not driven");
    a_write_hiz: assert property (s_wr_load |-> ##2 !dq_oe_mem)
        else $error("port drives lanes in write data cycle");
    a_write_cont: assert property (s_wr_load ##1 s_adv |-> ##2 !dq_oe_mem)
        else $error("port drives lanes in continued write");
    a_write_data: assert property (s_wr_load |-> ##2 (dq_oe_ctl || sleep_request))
        else $error("controller missing write data cycle");
    a_abort_quiet: assert property (s_ab_load |-> ##2 !dq_oe_mem)
        else $error("write abort drove the lanes");
    a_deselect_quiet: assert property (ld && !sel |-> ##2 !dq_oe_mem)
        else $error("deselect drove the lanes");
    a_oe_mask: assert property (!output_drive_enable |-> !dq_oe_mem)
        else $error("lanes driven with drive enable low");
    a_sleep_hiz: assert property (sleep_request [*6] |-> !dq_oe_mem)
        else $error("lanes driven while asleep");
    a_no_clash: assert property (!(dq_oe_mem && dq_oe_ctl))
        else $error("both ends drive the lanes");
    a_reset_hiz: assert property ($rose(rst_n) |-> !dq_oe_mem)
        else $error("lanes driven straight after reset");
endmodule

// ### tb/pipelined_sync_sram_port_test.sv
/*
 * Self-checking bench: controller and SRAM port joined pin to pin.
 * Assumes package, interface, FIFO and both ends are compiled first.
 */
`timescale 1ns/1ps
module pipelined_sync_sram_port_test;
    import pss_pkg::*;
    localparam int WW = DATA_W + LANES;
    typedef struct packed {logic wr; logic burst; logic order;
                           logic [ADDR_W-1:0] addr; logic [LANES-1:0] lanes_n;} pss_row_t;
    // Fields: write, burst, interleaved, address, lane selects
    localparam pss_row_t ROWS [12] = '{
        '{1'h1, 1'h1, 1'h0, 10'h012, 4'h0}, '{1'h0, 1'h1, 1'h0, 10'h012, 4'h0},
        '{1'h0, 1'h1, 1'h1, 10'h013, 4'h0}, '{1'h1, 1'h0, 1'h0, 10'h011, 4'h5},
        '{1'h1, 1'h0, 1'h0, 10'h010, 4'ha}, '{1'h0, 1'h0, 1'h0, 10'h011, 4'h0},
        '{1'h1, 1'h1, 1'h1, 10'h022, 4'h0}, '{1'h0, 1'h1, 1'h0, 10'h021, 4'h0},
        '{1'h1, 1'h1, 1'h0, 10'h012, 4'h7}, '{1'h0, 1'h1, 1'h1, 10'h010, 4'h3},
        '{1'h1, 1'h0, 1'h0, 10'h023, 4'he}, '{1'h0, 1'h0, 1'h0, 10'h023, 4'h0}};

    logic                core_clk    = 1'h0;
    logic                rst_n       = 1'h0;
    logic                req_valid   = 1'h0;
    logic                req_ready;
    logic                req_write   = 1'h0;
    logic                req_burst   = 1'h0;
    logic [ADDR_W-1:0]   req_addr    = 10'h000;
    logic [LANES-1:0]    req_lanes_n = 4'hf;
    logic                req_order   = 1'h0;
    logic                wd_valid    = 1'h0;
    logic                wd_ready;
    logic [WW-1:0]       wd_data     = 36'h0;
    logic                rd_valid;
    logic [WW-1:0]       rd_data;
    logic                sleep_req   = 1'h0;
    logic                oe_req      = 1'h1;
    logic [7:0]          hits;
    logic [WW-1:0]       model [DEPTH];
    logic [WW-1:0]       rd_q [$];
    logic [WW-1:0]       wq [$];
    int                  err_total   = 0;
    int                  tests_run   = 0;
    int                  cycles      = 0;
    int                  seq         = 1;

    // ----------------------------------------
    // Both ends, shared lanes and checker
    // ----------------------------------------
    pss_if i_pss_if ();
    pss_ctl i_pss_ctl (.core_clk, .rst_n, .req_valid, .req_ready, .req_write, .req_burst,
        .req_addr, .req_lanes_n, .req_order, .wd_valid, .wd_ready, .wd_data, .rd_valid,
        .rd_data, .sleep_req, .oe_req, .pin(i_pss_if.ctl));
    pss_mem i_pss_mem (.core_clk, .rst_n, .pin(i_pss_if.mem));
    // Undriven lanes show a changing pattern, never a stale value
    assign i_pss_if.dq_in = i_pss_if.dq_oe_mem ? i_pss_if.dq_from_mem :
        i_pss_if.dq_oe_ctl ? i_pss_if.dq_from_ctl : {LANES{cycles[7:0]}};
    assign i_pss_if.parity_lanes_in = i_pss_if.dq_oe_mem ? i_pss_if.parity_lanes_from_mem :
        i_pss_if.dq_oe_ctl ? i_pss_if.parity_lanes_from_ctl : cycles[3:0];
    pss_properties i_pss_properties (.core_clk, .rst_n,
        .clock_gate_n(i_pss_if.clock_gate_n), .chip_select_first(i_pss_if.chip_select_first),
        .chip_select_second(i_pss_if.chip_select_second),
        .chip_select_third(i_pss_if.chip_select_third),
        .advance_or_load(i_pss_if.advance_or_load), .write_select(i_pss_if.write_select),
        .byte_lane_write(i_pss_if.byte_lane_write), .sleep_request(i_pss_if.sleep_request),
        .output_drive_enable(i_pss_if.output_drive_enable),
        .dq_oe_mem(i_pss_if.dq_oe_mem), .dq_oe_ctl(i_pss_if.dq_oe_ctl));

    always #2.5 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (rd_valid === 1'h1)
            rd_q.push_back(rd_data);
        if (cycles == 20000)
        begin
            err_total++;
            close_out();
        end
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [WW-1:0] seen, input logic [WW-1:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wait_hi(ref logic s);
        for (int t = 0; t < 200 && s !== 1'h1; t++)
            @(negedge core_clk);
        if (s !== 1'h1)
            err_total++;
    endtask

    function automatic logic [WW-1:0] merge(logic [WW-1:0] o, logic [WW-1:0] n,
                                            logic [LANES-1:0] ln);
        for (int g = 0; g < LANES; g++)
            if (!ln[g])
            begin
                o[LANE_W*g +: LANE_W] = n[LANE_W*g +: LANE_W];
                o[DATA_W+g] = n[DATA_W+g];
            end
        return o;
    endfunction

    // Valid stays up across words; dropped one edge after the last
    task automatic push(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(negedge core_clk);
            wd_valid = 1'h1;
            wd_data = {4'(seq), 32'(seq) * 32'h0101_0101 ^ 32'h5ac3_3ca5};
            wq.push_back(wd_data);
            seq++;
            wait_hi(wd_ready);
        end
        @(negedge core_clk);
        wd_valid = 1'h0;
    endtask

    task automatic req(input pss_row_t r);
        rd_q.delete();
        @(negedge core_clk);
        req_valid = 1'h1;
        {req_write, req_burst, req_order, req_addr, req_lanes_n} = r;
        wait_hi(req_ready);
        req_valid = 1'h0;
    endtask

    task automatic op(input pss_row_t r, input bit fill);
        logic [ADDR_W-1:0] a;
        if (r.wr && fill)
            push(r.burst ? 4 : 1);
        req(r);
        for (int k = 0; k < (r.burst ? 4 : 1); k++)
        begin
            a = {r.addr[ADDR_W-1:2], r.order ? r.addr[1:0] ^ 2'(k) : r.addr[1:0] + 2'(k)};
            if (r.wr)
                model[a] = merge(model[a], wq.pop_front(), r.lanes_n);
            else
            begin
                for (int t = 0; t < 100 && rd_q.size() == 0; t++)
                    @(negedge core_clk);
                check(rd_q.pop_front(), model[a]);
            end
        end
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(negedge core_clk);
        rst_n = 1'h1;
        foreach (ROWS[i])
            op(ROWS[i], 1'h1);
        // Fill the write FIFO with nothing draining it
        push(8);
        check(wd_ready, 1'h0);
        op(pss_row_t'{1'h1, 1'h1, 1'h0, 10'h040, 4'h0}, 1'h0);
        op(pss_row_t'{1'h1, 1'h1, 1'h1, 10'h046, 4'h0}, 1'h0);
        check(wd_ready, 1'h1);
        op(pss_row_t'{1'h0, 1'h1, 1'h0, 10'h040, 4'h0}, 1'h1);
        op(pss_row_t'{1'h0, 1'h1, 1'h0, 10'h045, 4'h0}, 1'h1);
        // Reads with drive enable low
        oe_req = 1'h0;
        repeat (3) @(negedge core_clk);
        req(ROWS[1]);
        hits = 8'h00;
        repeat (12)
        begin
            @(negedge core_clk);
            hits = hits + 8'(i_pss_if.dq_oe_mem);
        end
        check(hits, 0);
        oe_req = 1'h1;
        sleep_req = 1'h1;
        repeat (10) @(negedge core_clk);
        check(i_pss_if.dq_oe_mem, 1'h0);
        sleep_req = 1'h0;
        repeat (10) @(negedge core_clk);
        op(ROWS[7], 1'h1);
        rst_n = 1'h0;
        repeat (12) @(negedge core_clk);
        rst_n = 1'h1;
        @(negedge core_clk);
        check(i_pss_if.dq_oe_mem, 1'h0);
        // Every lane pattern; all lanes high is the abort, kept last
        for (int l = 0; l < 16; l++)
        begin
            op(pss_row_t'{1'h1, 1'h0, 1'h0, 10'h030, 4'(l)}, 1'h1);
            op(pss_row_t'{1'h0, 1'h0, 1'h0, 10'h030, 4'(l)}, 1'h1);
        end
        close_out();
    end
endmodule
